// ### hw/ulpc_consts.vh
// ulpc_consts.vh - register map, field positions, reset values and timing counts
// assumes: included by the link power config modules, 32-bit apb data
`ifndef ULPC_CONSTS_VH
`define ULPC_CONSTS_VH

// register map
`define ULPC_CFG_ADDR        12'h084
`define ULPC_ADDR_W          12

// field positions of the link power config register
`define ULPC_U1_WAIT_HI      31
`define ULPC_U1_WAIT_LO      24
`define ULPC_U2_PORT_HI      23
`define ULPC_U2_PORT_LO      16
`define ULPC_HS_TRIM_HI      15
`define ULPC_HS_TRIM_LO      13
`define ULPC_U2_SELF_BIT     12
`define ULPC_U2_HOST_BIT     11

// reset values
`define ULPC_U1_WAIT_RST     8'h00
`define ULPC_U2_PORT_RST     8'h00
`define ULPC_HS_TRIM_RST     3'h0
`define ULPC_U2_SELF_RST     1'b0
`define ULPC_U2_HOST_RST     1'b0

// timing: clock rate and one microsecond in cycles
`define ULPC_CLK_MHZ         250
`define ULPC_US_NS           1000
`define ULPC_CLK_NS          4
`define ULPC_US_CYCLES       (`ULPC_US_NS / `ULPC_CLK_NS)
`define ULPC_PRE_W           8
`define ULPC_US_LAST         8'd249

// high speed gap timeout, bit times
`define ULPC_HS_MIN_BITS     736
`define ULPC_HS_MAX_BITS     816
`define ULPC_HS_BASE_BITS    10'd800
`define ULPC_HS_PER60_BITS   7'd8
`define ULPC_HS_PER30_BITS   7'd16
`define ULPC_HS_GAP_W        10

`endif

// ### hw/ulpc_hs_gap.v
// ulpc_hs_gap.v - high speed inter-packet timeout with phy delay trim
// assumes: trim is a programmed field on mclk; only a 60 MHz phy clock exists
`timescale 1ns/1ps
`include "ulpc_consts.vh"

module ulpc_hs_gap (
   input  wire                      mclk,
   input  wire                      rst,
   input  wire                      ce,
   input  wire [2:0]                hsTrim,
   output reg  [`ULPC_HS_GAP_W-1:0] hsGapBits
);

   ////////////////////////////////////////////////////////////////////////////
   // base window value plus trim times the per-clock factor
   wire [6:0]                  perClk  = `ULPC_HS_PER60_BITS;
   wire [`ULPC_HS_GAP_W-1:0]   addBits = {3'h0, perClk} * {7'h00, hsTrim};
   wire [`ULPC_HS_GAP_W-1:0]   baseBits = `ULPC_HS_BASE_BITS;

   always @(posedge mclk) begin
      if (rst)
         hsGapBits <= `ULPC_HS_BASE_BITS;
      else if (ce)
         hsGapBits <= baseBits + addBits;
   end

endmodule // ulpc_hs_gap

// ### hw/ulpc_top.v
// ulpc_top.v - usb link power config register with apb slave, u1 timer and hs gap trim
// assumes: apb master and usb link logic share mclk; reset image inputs are stable
`timescale 1ns/1ps
`include "ulpc_consts.vh"

// How it works
// - once the host enables u1, the device waits u1_idle_wait microseconds of idle link before asking for u1.
// - the port timeout field is read only, resets to zero and shows the value from the port's u2_idle_timeout_from_port lmp.
// - the trim count times a per-clock factor is added to the high speed gap timeout.
// - each trim count adds 8 bit times at 60 MHz and 16 at 30 MHz.
// - only the 60 MHz factor is ever applied.
// - the base high speed gap timeout lies within 736 to 816 bit times.
// - self-started u2 needs both the self entry bit and the host's u2 feature enable.
// - host u2 requests are accepted only while the host accept bit is set.
// - the two u2 bits act independently of each other.
// - both u2 bits keep their value across a guarded usb or lite reset.
// - u1_idle_wait resets to the loaded image or zero, also on usb reset and lite reset.
module ulpc_top (
   input  wire                      mclk,
   input  wire                      rst,
   input  wire                      ce,
   input  wire                      psel,
   input  wire                      penable,
   input  wire                      pwrite,
   input  wire [`ULPC_ADDR_W-1:0]   paddr,
   input  wire [31:0]               pwdata,
   input  wire [3:0]                pstrb,
   output reg  [31:0]               prdata,
   output wire                      pready,
   output wire                      pslverr,
   input  wire                      usbReset,
   input  wire                      liteReset,
   input  wire                      softResetGuard,
   input  wire                      imageValid,
   input  wire [7:0]                imageU1IdleWait,
   input  wire                      u1HostEnabled,
   input  wire                      u2HostEnabled,
   input  wire                      linkIdle,
   input  wire                      lmpValid,
   input  wire [7:0]                lmpU2Timeout,
   input  wire                      u2HostRequest,
   output wire                      u1Request,
   output wire                      u1Armed,
   output reg                       u2SelfEntryOk,
   output reg                       u2HostAck,
   output reg                       u2HostReject,
   output wire [`ULPC_HS_GAP_W-1:0] hsGapBits,
   output wire [7:0]                u2IdleTimeoutFromPort
);

   ////////////////////////////////////////////////////////////////////////////
   // register state
   reg  [7:0]  u1IdleWait_q;
   reg  [7:0]  u1IdleWait_d;
   reg  [7:0]  u2IdleTimeoutFromPort_q;
   reg  [7:0]  u2IdleTimeoutFromPort_d;
   reg  [2:0]  hsGapTimeoutTrim_q;
   reg  [2:0]  hsGapTimeoutTrim_d;
   reg         u2SelfEntryAllow_q;
   reg         u2SelfEntryAllow_d;
   reg         u2HostRequestAccept_q;
   reg         u2HostRequestAccept_d;

   ////////////////////////////////////////////////////////////////////////////
   // apb decode
   wire        addrHit;
   wire        setupPhase;
   wire        accessPhase;
   wire        wrEn;
   wire        linkReset;
   wire [31:0] regImage;
   wire [7:0]  u1ResetValue;

   assign addrHit     = (paddr == `ULPC_CFG_ADDR);
   assign setupPhase  = psel & ~penable;
   assign accessPhase = psel & penable;
   assign pready      = ce;
   assign pslverr     = accessPhase & ~addrHit;
   assign wrEn        = accessPhase & pready & pwrite & addrHit;
   assign linkReset   = usbReset | liteReset;

   assign u1ResetValue = imageValid ? imageU1IdleWait : `ULPC_U1_WAIT_RST;

   assign regImage = {u1IdleWait_q,
                      u2IdleTimeoutFromPort_q,
                      hsGapTimeoutTrim_q,
                      u2SelfEntryAllow_q,
                      u2HostRequestAccept_q,
                      11'h000};

   ////////////////////////////////////////////////////////////////////////////
   // next values of the programmed fields
   always @* begin
      u1IdleWait_d          = u1IdleWait_q;
      hsGapTimeoutTrim_d    = hsGapTimeoutTrim_q;
      u2SelfEntryAllow_d    = u2SelfEntryAllow_q;
      u2HostRequestAccept_d = u2HostRequestAccept_q;
      if (wrEn) begin
         if (pstrb[3])
            u1IdleWait_d = pwdata[`ULPC_U1_WAIT_HI:`ULPC_U1_WAIT_LO];
         if (pstrb[1]) begin
            hsGapTimeoutTrim_d    = pwdata[`ULPC_HS_TRIM_HI:`ULPC_HS_TRIM_LO];
            u2SelfEntryAllow_d    = pwdata[`ULPC_U2_SELF_BIT];
            u2HostRequestAccept_d = pwdata[`ULPC_U2_HOST_BIT];
         end
      end
      if (linkReset) begin
         u1IdleWait_d       = u1ResetValue;
         hsGapTimeoutTrim_d = `ULPC_HS_TRIM_RST;
         if (!softResetGuard) begin
            u2SelfEntryAllow_d    = `ULPC_U2_SELF_RST;
            u2HostRequestAccept_d = `ULPC_U2_HOST_RST;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // port u2_idle_timeout_from_port copy, software cannot write it
   always @* begin
      u2IdleTimeoutFromPort_d = u2IdleTimeoutFromPort_q;
      if (linkReset)
         u2IdleTimeoutFromPort_d = `ULPC_U2_PORT_RST;
      if (lmpValid)
         u2IdleTimeoutFromPort_d = lmpU2Timeout;
   end

   ////////////////////////////////////////////////////////////////////////////
   // register flops
   always @(posedge mclk) begin
      if (rst) begin
         u1IdleWait_q            <= u1ResetValue;
         u2IdleTimeoutFromPort_q <= `ULPC_U2_PORT_RST;
         hsGapTimeoutTrim_q      <= `ULPC_HS_TRIM_RST;
         u2SelfEntryAllow_q      <= `ULPC_U2_SELF_RST;
         u2HostRequestAccept_q   <= `ULPC_U2_HOST_RST;
      end else if (ce) begin
         u1IdleWait_q            <= u1IdleWait_d;
         u2IdleTimeoutFromPort_q <= u2IdleTimeoutFromPort_d;
         hsGapTimeoutTrim_q      <= hsGapTimeoutTrim_d;
         u2SelfEntryAllow_q      <= u2SelfEntryAllow_d;
         u2HostRequestAccept_q   <= u2HostRequestAccept_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // read data is captured in the setup cycle
   always @(posedge mclk) begin
      if (rst)
         prdata <= 32'h0000_0000;
      else if (ce && setupPhase)
         prdata <= (addrHit && !pwrite) ? regImage : 32'h0000_0000;
   end

   assign u2IdleTimeoutFromPort = u2IdleTimeoutFromPort_q;

   ////////////////////////////////////////////////////////////////////////////
   // u2 permissions, each bit on its own
   always @(posedge mclk) begin
      if (rst) begin
         u2SelfEntryOk <= 1'b0;
         u2HostAck     <= 1'b0;
         u2HostReject  <= 1'b0;
      end else if (ce) begin
         u2SelfEntryOk <= u2SelfEntryAllow_q & u2HostEnabled;
         u2HostAck     <= u2HostRequest & u2HostRequestAccept_q;
         u2HostReject  <= u2HostRequest & ~u2HostRequestAccept_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // u1 idle timer
   ulpc_u1_timer u1Timer (
      .mclk          (mclk),
      .rst           (rst),
      .ce            (ce),
      .u1HostEnabled (u1HostEnabled),
      .linkIdle      (linkIdle),
      .u1IdleWait    (u1IdleWait_q),
      .u1Request     (u1Request),
      .u1Armed       (u1Armed)
   );

   ////////////////////////////////////////////////////////////////////////////
   // high speed gap timeout
   ulpc_hs_gap hsGap (
      .mclk      (mclk),
      .rst       (rst),
      .ce        (ce),
      .hsTrim    (hsGapTimeoutTrim_q),
      .hsGapBits (hsGapBits)
   );

endmodule // ulpc_top

// ### hw/ulpc_u1_timer.v
// ulpc_u1_timer.v - microsecond idle counter that raises the u1 entry request
// assumes: linkIdle and u1HostEnabled are on mclk; ce freezes all state
`timescale 1ns/1ps
`include "ulpc_consts.vh"

module ulpc_u1_timer (
   input  wire       mclk,
   input  wire       rst,
   input  wire       ce,
   input  wire       u1HostEnabled,
   input  wire       linkIdle,
   input  wire [7:0] u1IdleWait,
   output reg        u1Request,
   output reg        u1Armed
);

   ////////////////////////////////////////////////////////////////////////////
   // prescaler and microsecond count, restarted by any link activity
   reg  [`ULPC_PRE_W-1:0] preQ;
   reg  [7:0]             usQ;
   wire                   run = u1HostEnabled & linkIdle;
   wire                   usTick = (preQ == `ULPC_US_LAST);
   wire                   reached = run & ~u1Armed & (usQ >= u1IdleWait);

   always @(posedge mclk) begin
      if (rst) begin
         preQ      <= {`ULPC_PRE_W{1'b0}};
         usQ       <= 8'h00;
         u1Request <= 1'b0;
         u1Armed   <= 1'b0;
      end else if (ce) begin
         u1Request <= 1'b0;
         if (!run) begin
            preQ    <= {`ULPC_PRE_W{1'b0}};
            usQ     <= 8'h00;
            u1Armed <= 1'b0;
         end else begin
            preQ <= usTick ? {`ULPC_PRE_W{1'b0}} : preQ + 1'b1;
            if (usTick && usQ != 8'hff)
               usQ <= usQ + 8'h01;
            if (reached) begin
               u1Request <= 1'b1;
               u1Armed   <= 1'b1;
            end
         end
      end
   end

endmodule // ulpc_u1_timer

// ### test/test_usb_link_power_config.sv
// test_usb_link_power_config.sv - self-checking bench for the link power config block
// assumes: apb master and host model share mclk; ce held high
`timescale 1ns/1ps
`include "ulpc_consts.vh"
module test_usb_link_power_config;
   logic        mclk, rst, ce, psel, penable, pwrite, usbReset, liteReset, softResetGuard, imageValid;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, d, cfgExp;
   logic [3:0]  pstrb;
   logic [7:0]  imageU1IdleWait, lmpU2Timeout, u2IdleTimeoutFromPort, v;
   logic [9:0]  hsGapBits;
   logic        pready, pslverr, lmpValid, u2HostRequest, u1HostEnabled, u2HostEnabled, linkIdle;
   logic        u1Request, u1Armed, u2SelfEntryOk, u2HostAck, u2HostReject;
   logic [32:0] qRd[$];
   logic [1:0]  qU2[$];
   int          errors = 0, n_tests = 0, n;
   ulpc_top i_dut (.mclk, .rst, .ce, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr,
      .usbReset, .liteReset, .softResetGuard, .imageValid, .imageU1IdleWait, .u1HostEnabled, .u2HostEnabled,
      .linkIdle, .lmpValid, .lmpU2Timeout, .u2HostRequest, .u1Request, .u1Armed, .u2SelfEntryOk, .u2HostAck,
      .u2HostReject, .hsGapBits, .u2IdleTimeoutFromPort);
   ulpc_host_model i_host (.mclk, .lmpValid, .lmpU2Timeout, .u2HostRequest, .u1HostEnabled, .u2HostEnabled, .linkIdle);
   always #2 mclk = ~mclk;
   ////////////////////////////////////////
   task check(input logic [32:0] seen, exp);
      n_tests++;
      if (seen !== exp) begin
         errors++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task print_verdict();
      $display("errors %0d of %0d checks", errors, n_tests);
      if (errors == 0 && n_tests > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   task apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= wd;
      @(posedge mclk);
      penable <= 1'b1;
      do @(posedge mclk); while (pready !== 1'b1);
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge mclk);
   endtask
   task rd(input logic [11:0] a, input logic [32:0] e);
      qRd.push_back(e);
      apb(1'b0, a, 32'h0);
   endtask
   // result watcher: oldest note against each answer
   always @(posedge mclk) begin
      if (psel && penable && pready && !pwrite)
         check({pslverr, prdata}, qRd.pop_front());
      if (u2HostAck || u2HostReject)
         check({u2HostAck, u2HostReject}, qU2.pop_front());
   end
   initial begin
      #80000;
      errors++;
      print_verdict();
   end
   initial begin
      {rst, ce, pstrb, imageValid} = 7'h7f;
      {psel, penable, pwrite, usbReset, liteReset, softResetGuard} = 6'h0;
      {paddr, pwdata} = 44'h0;
      mclk = 1'b0;
      void'($urandom(45588));
      imageU1IdleWait = $urandom;
      repeat (6) @(posedge mclk);
      rst <= 1'b0;
      rd(`ULPC_CFG_ADDR, {1'b0, imageU1IdleWait, 24'h0});
      check(hsGapBits, 10'd800);
      for (int i = 0; i < 8; i++) begin
         d = $urandom;
         d[15:11] = {i[2:0], i[1:0]};
         cfgExp = {d[31:24], 8'h0, d[15:11], 11'h0};
         apb(1'b1, `ULPC_CFG_ADDR, d);
         rd(`ULPC_CFG_ADDR, {1'b0, cfgExp});
         i_host.set(1'b0, i[2], 1'b0);
         qU2.push_back({d[11], ~d[11]});
         i_host.ask();
         @(posedge mclk);
         check(hsGapBits, 10'd800 + 10'(8 * i));
         check(u2SelfEntryOk, d[12] & i[2]);
      end
      v = $urandom;
      i_host.lmp(~v);
      i_host.lmp(v);
      cfgExp[23:16] = v;
      check(u2IdleTimeoutFromPort, v);
      rd(`ULPC_CFG_ADDR, {1'b0, cfgExp});
      apb(1'b1, `ULPC_CFG_ADDR, cfgExp ^ 32'h00ff0000);
      rd(`ULPC_CFG_ADDR, {1'b0, cfgExp});
      rd(12'h088, {1'b1, 32'h0});
      softResetGuard <= 1'b1;
      usbReset <= 1'b1;
      @(posedge mclk);
      usbReset <= 1'b0;
      rd(`ULPC_CFG_ADDR, {1'b0, imageU1IdleWait, 11'h0, cfgExp[12:11], 11'h0});
      softResetGuard <= 1'b0;
      liteReset <= 1'b1;
      @(posedge mclk);
      liteReset <= 1'b0;
      rd(`ULPC_CFG_ADDR, {1'b0, imageU1IdleWait, 24'h0});
      imageValid <= 1'b0;
      liteReset <= 1'b1;
      @(posedge mclk);
      liteReset <= 1'b0;
      rd(`ULPC_CFG_ADDR, {1'b0, 32'h0});
      apb(1'b1, `ULPC_CFG_ADDR, 32'h01000000);
      i_host.set(1'b1, 1'b0, 1'b1);
      n = 0;
      while (u1Request !== 1'b1 && n < 400) begin
         @(posedge mclk);
         n++;
      end
      check(n >= 248 && n <= 256, 1'b1);
      @(posedge mclk);
      check(u1Armed, 1'b1);
      i_host.set(1'b0, 1'b0, 1'b0);
      repeat (4) @(posedge mclk);
      check(qRd.size() + qU2.size(), 0);
      print_verdict();
   end
endmodule // test_usb_link_power_config

// ### test/ulpc_host_model.sv
// ulpc_host_model.sv - upstream port model: lmp, host u2 requests, enables, link idle
// assumes: tasks are called just after a rising mclk edge
`timescale 1ns/1ps
module ulpc_host_model (
   input  logic       mclk,
   output logic       lmpValid,
   output logic [7:0] lmpU2Timeout,
   output logic       u2HostRequest,
   output logic       u1HostEnabled,
   output logic       u2HostEnabled,
   output logic       linkIdle
);
   ////////////////////////////////////////
   initial begin
      lmpValid = 1'b0;
      lmpU2Timeout = 8'h5a;
      u2HostRequest = 1'b0;
      {u1HostEnabled, u2HostEnabled, linkIdle} = 3'h0;
   end
   // one lmp pulse carrying the timeout the hub was given
   task lmp(input logic [7:0] v);
      lmpValid <= 1'b1;
      lmpU2Timeout <= v;
      @(posedge mclk);
      lmpValid <= 1'b0;
      lmpU2Timeout <= ~v;
      @(posedge mclk);
   endtask
   task ask();
      u2HostRequest <= 1'b1;
      @(posedge mclk);
      u2HostRequest <= 1'b0;
      @(posedge mclk);
   endtask
   task set(input logic u1, u2, idle);
      u1HostEnabled <= u1;
      u2HostEnabled <= u2;
      linkIdle <= idle;
   endtask
endmodule // ulpc_host_model

// ### test/ulpc_top_properties.sv
// ulpc_top_properties.sv - port assertions for the link power config block
// assumes: one mclk domain, rst synchronous active high
`timescale 1ns/1ps
module ulpc_top_properties (
   input logic       mclk,
   input logic       rst,
   input logic       ce,
   input logic       lmpValid,
   input logic [7:0] lmpU2Timeout,
   input logic       usbReset,
   input logic       liteReset,
   input logic       u2HostRequest,
   input logic       u2HostAck,
   input logic       u2HostReject,
   input logic       u2HostEnabled,
   input logic       u2SelfEntryOk,
   input logic       u1HostEnabled,
   input logic       linkIdle,
   input logic       u1Request,
   input logic [9:0] hsGapBits,
   input logic [7:0] u2IdleTimeoutFromPort
);
   ////////////////////////////////////////
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);
   sequence s_u1Pulse; $rose(u1Request); endsequence
   sequence s_u1Gone; !u1Request; endsequence
   property p_lmp; ce && lmpValid |=> u2IdleTimeoutFromPort == $past(lmpU2Timeout); endproperty
   a_lmp: assert property (p_lmp) else $error("lmp value lost");
   property p_hold; ce && !lmpValid && !usbReset && !liteReset |=> $stable(u2IdleTimeoutFromPort); endproperty
   a_hold: assert property (p_hold) else $error("port timeout moved");
   property p_ack; ce && u2HostRequest |=> u2HostAck != u2HostReject; endproperty
   a_ack: assert property (p_ack) else $error("no single u2 answer");
   property p_quiet; ce && !u2HostRequest |=> !u2HostAck && !u2HostReject; endproperty
   a_quiet: assert property (p_quiet) else $error("u2 answer unasked");
   property p_gap; hsGapBits >= 10'd800 && hsGapBits <= 10'd856 && hsGapBits[2:0] == 3'h0; endproperty
   a_gap: assert property (p_gap) else $error("gap timeout off grid");
   property p_u1Src; s_u1Pulse |-> $past(u1HostEnabled) && $past(linkIdle); endproperty
   a_u1Src: assert property (p_u1Src) else $error("u1 asked while busy");
   property p_u1One; s_u1Pulse |=> s_u1Gone; endproperty
   a_u1One: assert property (p_u1One) else $error("u1 pulse too long");
   property p_self; ce && !u2HostEnabled |=> !u2SelfEntryOk; endproperty
   a_self: assert property (p_self) else $error("u2 self entry ungated");
endmodule // ulpc_top_properties
bind ulpc_top ulpc_top_properties i_props (.mclk, .rst, .ce, .lmpValid, .lmpU2Timeout, .usbReset, .liteReset,
   .u2HostRequest, .u2HostAck, .u2HostReject, .u2HostEnabled, .u2SelfEntryOk, .u1HostEnabled, .linkIdle,
   .u1Request, .hsGapBits, .u2IdleTimeoutFromPort);
